// ---- hdl/dma_channel_consts.vh ----
// Constants of the DMA channel control block.
`ifndef DMA_CHANNEL_CONSTS_VH
`define DMA_CHANNEL_CONSTS_VH
`define OFS_CONTROL     8'h00
`define OFS_SOURCE      8'h04
`define OFS_DEST        8'h08
`define OFS_COUNT       8'h0C
`define OFS_STATUS      8'h10
`define OFS_FIFO_DATA   8'h14
`define BIT_ENABLE      0
`define BIT_SIZE        1
`define BIT_DUMMY_WRITE 10
`define BIT_RELOAD      9
`define BIT_REQUEST     8
`define CONTROL_MASK    16'h07FF
`define CONTROL_RESET   16'h0000
`define MODE_UNCHANGED  2'h0
`define MODE_INCREMENT  2'h1
`define MODE_DECREMENT  2'h2
`define MODE_INDIRECT   2'h3
`define TR_ONE_SHOT     2'h0
`define TR_REP_ONE_SHOT 2'h1
`define TR_CONTINUOUS   2'h2
`define TR_REP_CONT     2'h3
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ---- hdl/data_fifo.v ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module data_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             aclk,      // Clock.
  input  wire             aresetn,   // Synchronous reset, active low.
  input  wire [WIDTH-1:0] in_data,   // Write data.
  input  wire             in_valid,  // Write request.
  output wire             in_ready,  // Room available.
  output wire [WIDTH-1:0] out_data,  // Head word.
  output wire             out_valid, // Head word present.
  input  wire             out_ready  // Head word taken.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            push;
  wire            pop;
  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != DEPTH[AW:0];
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// ---- hdl/dma_channel_control.v ----
// DMA channel: control register, address sequencing and data mover.
`timescale 1ns/100ps
`include "dma_channel_consts.vh"
// Operation
// - With dummy writes on, each destination write is followed by a source write.
// - Reload on: addresses and count restored when the next operation starts.
// - Repeated modes always restore the count, reload bit or not.
// - Only the original count is kept; addresses are rebuilt from it.
// - Software request starts transfers; hardware clears it on completion, except in continuous modes with the channel enabled.
// - Transfer mode governs how many transfers one request performs.
// - Source mode: keep, increment, decrement, or indirect and keep.
// - Destination mode uses the same four encodings.
// - Transfer mode: one-shot, repeated one-shot, continuous, repeated cont.
// - Size bit: set byte, clear word; step follows the size.
// - Enable bit turns the channel on or off.
// - Bits 15..13 and 11 read zero; bit 12 kept zero; reset to zero.
module dma_channel_control (
  input  wire        aclk,          // Clock, 200 MHz.
  input  wire        aresetn,       // Synchronous reset, active low.
  input  wire [7:0]  s_axi_awaddr,  // Write address.
  input  wire        s_axi_awvalid, // Write address valid.
  output reg         s_axi_awready, // Write address ready.
  input  wire [31:0] s_axi_wdata,   // Write data.
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire        s_axi_wvalid,  // Write data valid.
  output reg         s_axi_wready,  // Write data ready.
  output reg  [1:0]  s_axi_bresp,   // Write response.
  output reg         s_axi_bvalid,  // Write response valid.
  input  wire        s_axi_bready,  // Write response ready.
  input  wire [7:0]  s_axi_araddr,  // Read address.
  input  wire        s_axi_arvalid, // Read address valid.
  output reg         s_axi_arready, // Read address ready.
  output reg  [31:0] s_axi_rdata,   // Read data.
  output reg  [1:0]  s_axi_rresp,   // Read response.
  output reg         s_axi_rvalid,  // Read data valid.
  input  wire        s_axi_rready,  // Read data ready.
  output reg         mem_rd_req,    // Source read strobe.
  output reg  [15:0] mem_rd_addr,   // Source read address.
  input  wire [15:0] mem_rd_data,   // Source data, valid the cycle after.
  output reg         mem_wr_req,    // Write strobe.
  output reg  [15:0] mem_wr_addr,   // Write address.
  output reg  [15:0] mem_wr_data,   // Write data.
  output reg         mem_wr_byte,   // Write is one byte.
  output reg         xfer_done      // Pulse when a block completes.
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_READ  = 4'b0010;
  localparam ST_WRITE = 4'b0100;
  localparam ST_DUMMY = 4'b1000;

  // ****************************************
  // Registers and state.
  // ****************************************
  reg [15:0] control_reg;
  reg [15:0] source_address_reg;
  reg [15:0] destination_address_reg;
  reg [15:0] transfer_count_reg;
  reg [15:0] orig_count_reg;
  reg [3:0]  state_reg;
  reg        rd_pending_reg;
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        restart_reg;

  wire        enable     = control_reg[`BIT_ENABLE];
  wire        byte_mode  = control_reg[`BIT_SIZE];
  wire        request    = control_reg[`BIT_REQUEST];
  wire [1:0]  src_mode   = control_reg[7:6];
  wire [1:0]  dst_mode   = control_reg[5:4];
  wire [1:0]  tr_mode    = control_reg[3:2];
  wire        repeated   = tr_mode[0];
  wire        continuous = tr_mode[1];

  wire [15:0] fifo_head;
  wire        fifo_valid;
  wire        fifo_ready;
  wire        fifo_pop   = (state_reg == ST_WRITE) && fifo_valid;

  // Next address for one mode and step.
  function [15:0] step_addr;
    input [15:0] addr;
    input [1:0]  mode;
    input        is_byte;
    begin
      case (mode)
        `MODE_INCREMENT: step_addr = addr + (is_byte ? 16'h0001 : 16'h0002);
        `MODE_DECREMENT: step_addr = addr - (is_byte ? 16'h0001 : 16'h0002);
        default:         step_addr = addr;
      endcase
    end
  endfunction

  // Rebuild a starting address from the current one and the count done.
  function [15:0] rewind_addr;
    input [15:0] addr;
    input [1:0]  mode;
    input        is_byte;
    input [15:0] done;
    reg   [15:0] span;
    begin
      span = is_byte ? done : {done[14:0], 1'b0};
      case (mode)
        `MODE_INCREMENT: rewind_addr = addr - span;
        `MODE_DECREMENT: rewind_addr = addr + span;
        default:         rewind_addr = addr;
      endcase
    end
  endfunction

  data_fifo #(.WIDTH(16), .DEPTH(16), .AW(4)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (mem_rd_data),
    .in_valid  (rd_pending_reg),
    .in_ready  (fifo_ready),
    .out_data  (fifo_head),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************
  // AXI4-Lite write channel.
  // ****************************************
  wire aw_ok  = aw_held_reg | (s_axi_awvalid & s_axi_awready);
  wire w_ok   = w_held_reg | (s_axi_wvalid & s_axi_wready);
  wire wr_go  = aw_ok & w_ok & !s_axi_bvalid;
  wire [7:0]  wa = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0]  ws = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire [15:0] wmask = {{8{ws[1]}}, {8{ws[0]}}};
  wire wr_ctrl = wr_go && wa == `OFS_CONTROL;
  wire wr_src  = wr_go && wa == `OFS_SOURCE;
  wire wr_dst  = wr_go && wa == `OFS_DEST;
  wire wr_cnt  = wr_go && wa == `OFS_COUNT;
  wire wr_map  = wr_ctrl | wr_src | wr_dst | wr_cnt;
  // Written control value; unimplemented bits stay zero.
  wire [15:0] ctrl_wr = ((control_reg & ~wmask) | (wd[15:0] & wmask))
                        & `CONTROL_MASK;

  // A block finishes when the last write of a count lands.
  wire last_write = (state_reg == ST_WRITE && fifo_valid
                     && !control_reg[`BIT_DUMMY_WRITE]
                     || state_reg == ST_DUMMY)
                    && transfer_count_reg == 16'h0001;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= !aw_ok && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready  <= !w_ok && !s_axi_bvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg   <= 1'b0;
        w_held_reg    <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Channel engine.
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      control_reg             <= `CONTROL_RESET;
      source_address_reg      <= 16'h0000;
      destination_address_reg <= 16'h0000;
      transfer_count_reg      <= 16'h0000;
      orig_count_reg          <= 16'h0000;
      state_reg               <= ST_IDLE;
      rd_pending_reg          <= 1'b0;
      restart_reg             <= 1'b0;
      mem_rd_req              <= 1'b0;
      mem_rd_addr             <= 16'h0000;
      mem_wr_req              <= 1'b0;
      mem_wr_addr             <= 16'h0000;
      mem_wr_data             <= 16'h0000;
      mem_wr_byte             <= 1'b0;
      xfer_done               <= 1'b0;
    end else begin
      mem_rd_req     <= 1'b0;
      mem_wr_req     <= 1'b0;
      xfer_done      <= 1'b0;
      rd_pending_reg <= mem_rd_req;
      if (wr_src) source_address_reg <= wd[15:0];
      if (wr_dst) destination_address_reg <= wd[15:0];
      if (wr_cnt) begin
        transfer_count_reg <= wd[15:0];
        orig_count_reg     <= wd[15:0];
      end
      // New addresses or count from software replace any pending reload.
      if (wr_src || wr_dst || wr_cnt) restart_reg <= 1'b0;
      if (wr_ctrl) begin
        // A request written with the enable bit clear is dropped.
        control_reg <= ctrl_wr & ~(ctrl_wr[`BIT_ENABLE] ? 16'h0000
                                   : 16'h0100);
      end
      // Start of the next operation after a finished block.
      if (restart_reg && state_reg == ST_IDLE && request) begin
        restart_reg <= 1'b0;
        if (control_reg[`BIT_RELOAD] || repeated)
          transfer_count_reg <= orig_count_reg;
        if (control_reg[`BIT_RELOAD]) begin
          source_address_reg <= rewind_addr(source_address_reg, src_mode,
                                  byte_mode, orig_count_reg);
          destination_address_reg <= rewind_addr(destination_address_reg,
                                  dst_mode, byte_mode, orig_count_reg);
        end
      end
      case (state_reg)
        ST_IDLE: begin
          if (enable && request && !restart_reg
              && transfer_count_reg != 16'h0000 && fifo_ready) begin
            mem_rd_req  <= 1'b1;
            mem_rd_addr <= source_address_reg;
            state_reg   <= ST_READ;
          end
        end
        ST_READ: begin
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          if (fifo_valid) begin
            mem_wr_req  <= 1'b1;
            mem_wr_addr <= destination_address_reg;
            mem_wr_data <= byte_mode ? {8'h00, fifo_head[7:0]} : fifo_head;
            mem_wr_byte <= byte_mode;
            source_address_reg <= step_addr(source_address_reg, src_mode,
                                            byte_mode);
            destination_address_reg <= step_addr(destination_address_reg,
                                        dst_mode, byte_mode);
            if (control_reg[`BIT_DUMMY_WRITE]) begin
              state_reg <= ST_DUMMY;
            end else begin
              transfer_count_reg <= transfer_count_reg - 16'h0001;
              state_reg          <= ST_IDLE;
            end
          end
        end
        ST_DUMMY: begin
          mem_wr_req         <= 1'b1;
          mem_wr_addr        <= mem_rd_addr;
          transfer_count_reg <= transfer_count_reg - 16'h0001;
          state_reg          <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (last_write) begin
        xfer_done   <= 1'b1;
        restart_reg <= 1'b1;
        // One-shot modes drop the request; continuous ones keep going.
        // A control write from software in the same cycle wins.
        if (!continuous || !enable) begin
          if (!wr_ctrl) control_reg[`BIT_REQUEST] <= 1'b0;
          if (!repeated && !continuous && !wr_ctrl)
            control_reg[`BIT_ENABLE] <= 1'b0;
        end
      end
      // A disabled channel abandons its request.
      if (!enable && !wr_ctrl) control_reg[`BIT_REQUEST] <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel.
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_CONTROL: s_axi_rdata <= {16'h0000, control_reg};
          `OFS_SOURCE:  s_axi_rdata <= {16'h0000, source_address_reg};
          `OFS_DEST:    s_axi_rdata <= {16'h0000, destination_address_reg};
          `OFS_COUNT:   s_axi_rdata <= {16'h0000, transfer_count_reg};
          `OFS_STATUS:  s_axi_rdata <= {27'h0000000, fifo_valid,
                                        state_reg};
          `OFS_FIFO_DATA: s_axi_rdata <= {16'h0000, fifo_head};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- verification/mem_model.sv ----
// Memory model that answers the source reads of the DMA channel.
`timescale 1ns/100ps
module mem_model (
  input  wire        aclk,        // Clock.
  input  wire        mem_rd_req,  // Read strobe.
  input  wire [15:0] mem_rd_addr, // Read address.
  output wire [15:0] mem_rd_data  // Read data.
);
  // ****************************************
  // Read data path
  // ****************************************
  reg        hold_reg = 1'b0;
  reg [15:0] last_reg = 16'h0000;
  // Data holds one cycle past the strobe, then toggles every cycle.
  assign mem_rd_data = mem_rd_req ? (mem_rd_addr ^ 16'h5A3C) :
                       hold_reg ? last_reg : ~last_reg;
  always @(posedge aclk) begin
    hold_reg <= mem_rd_req;
    last_reg <= mem_rd_data;
  end
endmodule

// ---- verification/dma_channel_control_assertions.sv ----
// Concurrent checks on the ports of the DMA channel control block.
`timescale 1ns/100ps
module dma_channel_control_assertions (
  input wire        aclk,          // Clock.
  input wire        aresetn,       // Reset, active low.
  input wire [7:0]  s_axi_awaddr,  // Write address.
  input wire        s_axi_awvalid, // Write address valid.
  input wire        s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata,   // Write data.
  input wire        s_axi_wvalid,  // Write data valid.
  input wire        s_axi_wready,  // Write data ready.
  input wire [1:0]  s_axi_bresp,   // Write response.
  input wire        s_axi_bvalid,  // Write response valid.
  input wire        s_axi_bready,  // Write response ready.
  input wire        s_axi_arvalid, // Read address valid.
  input wire        s_axi_arready, // Read address ready.
  input wire [31:0] s_axi_rdata,   // Read data.
  input wire        s_axi_rvalid,  // Read data valid.
  input wire        s_axi_rready,  // Read data ready.
  input wire        mem_rd_req,    // Source read strobe.
  input wire        mem_wr_req,    // Write strobe.
  input wire        mem_wr_byte    // Byte write.
);
  // ****************************************
  // Control mirror and properties
  // ****************************************
  reg  size_reg;
  reg  dummy_reg;
  reg  en_reg;
  wire ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                s_axi_wready && s_axi_awaddr == 8'h00;
  // Mirrors the control bits that software wrote last.
  always @(posedge aclk) begin
    if (!aresetn) begin
      size_reg  <= 1'b0;
      dummy_reg <= 1'b0;
      en_reg    <= 1'b0;
    end else if (ctl_wr) begin
      size_reg  <= s_axi_wdata[1];
      dummy_reg <= s_axi_wdata[10];
      en_reg    <= s_axi_wdata[0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_move;
    ##3 mem_wr_req;
  endsequence
  sequence s_dummy;
    s_move ##1 mem_wr_req;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> !mem_rd_req && !mem_wr_req && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  write_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken too early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  read_to_write_a: assert property (mem_rd_req |-> s_move)
    else $error("read not followed by write");
  dummy_follow_a: assert property (dummy_reg && mem_rd_req |-> s_dummy)
    else $error("dummy write missing");
  byte_width_a: assert property (mem_wr_req |-> mem_wr_byte == size_reg)
    else $error("write width wrong");
  disabled_idle_a: assert property (!en_reg && !$past(en_reg) |-> !mem_rd_req)
    else $error("read while disabled");
endmodule
bind dma_channel_control dma_channel_control_assertions i_chk (.*);

// ---- verification/dma_channel_control_tb_top.sv ----
// Testbench of the DMA channel control block.
`timescale 1ns/100ps
`include "dma_channel_consts.vh"
module dma_channel_control_tb_top;
  reg         aclk;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00;
  reg  [7:0]  s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h00000000;
  reg  [3:0]  s_axi_wstrb = 4'h3;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, mem_rd_req, mem_wr_req, mem_wr_byte, xfer_done;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
  integer     n_mismatch = 0, check_count = 0, n_done = 0;
  reg  [15:0] rd_q[$], wa_q[$], wd_q[$];
  dma_channel_control i_dut (.*);
  mem_model i_mem (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (mem_rd_req) rd_q.push_back(mem_rd_addr);
    if (mem_wr_req) wa_q.push_back(mem_wr_addr);
    if (mem_wr_req) wd_q.push_back(mem_wr_data);
    if (xfer_done) n_done = n_done + 1;
  end
  // ****************************************
  // Bus tasks and scenarios
  // ****************************************
  task automatic check(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic axi_wr(input [7:0] a, input [15:0] d, input [1:0] er);
    reg aw, w;
    begin
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
        @(posedge aclk);
        if (s_axi_awready) aw = 1'b1;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) w = 1'b1;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      check({14'h0, s_axi_bresp}, {14'h0, er});
      s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd_chk(input [7:0] a, input [15:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      check({14'h0, s_axi_rresp}, {14'h0, er});
      if (er == `RESP_OKAY) check(s_axi_rdata[15:0], e);
      s_axi_rready <= 1'b0;
    end
  endtask
  task automatic setup(input [15:0] s, input [15:0] d, input [15:0] n);
    begin
      axi_wr(`OFS_SOURCE, s, `RESP_OKAY);
      axi_wr(`OFS_DEST, d, `RESP_OKAY);
      axi_wr(`OFS_COUNT, n, `RESP_OKAY);
    end
  endtask
  task automatic go(input [15:0] c, input integer k);
    begin
      rd_q.delete();
      wa_q.delete();
      wd_q.delete();
      n_done = 0;
      axi_wr(`OFS_CONTROL, c, `RESP_OKAY);
      while (n_done < k) @(posedge aclk);
      repeat (6) @(posedge aclk);
    end
  endtask
  function [15:0] step(input [15:0] a, input [1:0] m, input [15:0] st);
    step = m == `MODE_INCREMENT ? a + st : m == `MODE_DECREMENT ? a - st : a;
  endfunction
  task automatic moves(input [15:0] c, input [15:0] s, input [15:0] d,
                       input integer n);
    integer i, k;
    reg [15:0] sa, da, st, bm;
    begin
      st = c[1] ? 16'h0001 : 16'h0002;
      bm = c[1] ? 16'h00FF : 16'hFFFF;
      sa = s;
      da = d;
      k = 0;
      check(16'(rd_q.size()), 16'(n));
      for (i = 0; i < n; i = i + 1) begin
        check(rd_q[i], sa);
        check(wa_q[k], da);
        check(wd_q[k] & bm, (sa ^ 16'h5A3C) & bm);
        k = k + 1;
        if (c[10]) check(wa_q[k], sa);
        if (c[10]) k = k + 1;
        sa = step(sa, c[7:6], st);
        da = step(da, c[5:4], st);
      end
      check(16'(wa_q.size()), 16'(k));
    end
  endtask
  task automatic t_regs;
    begin
      rd_chk(`OFS_CONTROL, 16'h0000, `RESP_OKAY);
      rd_chk(`OFS_STATUS, 16'h0001, `RESP_OKAY);
      axi_wr(`OFS_CONTROL, 16'hE8FE, `RESP_OKAY);
      rd_chk(`OFS_CONTROL, 16'h00FE, `RESP_OKAY);
      axi_wr(`OFS_CONTROL, 16'h0000, `RESP_OKAY);
      axi_wr(8'h18, 16'h1234, `RESP_SLVERR);
      rd_chk(8'h18, 16'h0000, `RESP_SLVERR);
    end
  endtask
  task automatic t_modes;
    integer i;
    reg [15:0] c;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        c = {5'h00, i[1], 2'h1, i[1:0], 2'h3 - i[1:0], 2'h0, i[0], 1'b1};
        setup(16'h1000, 16'h2000, 16'h0003);
        go(c, 1);
        moves(c, 16'h1000, 16'h2000, 3);
        rd_chk(`OFS_CONTROL, c & 16'hFEFE, `RESP_OKAY);
      end
    end
  endtask
  task automatic t_reload;
    begin
      setup(16'h1000, 16'h2000, 16'h0002);
      go(16'h0155, 1);
      go(16'h0155, 1);
      moves(16'h0155, 16'h1004, 16'h2004, 2);
      rd_chk(`OFS_CONTROL, 16'h0055, `RESP_OKAY);
      setup(16'h1000, 16'h2000, 16'h0002);
      go(16'h0351, 1);
      go(16'h0351, 1);
      moves(16'h0351, 16'h1000, 16'h2000, 2);
    end
  endtask
  task automatic t_off;
    begin
      go(16'h0100, 0);
      repeat (20) @(posedge aclk);
      check(16'(rd_q.size()), 16'h0000);
      rd_chk(`OFS_CONTROL, 16'h0000, `RESP_OKAY);
    end
  endtask
  task automatic t_cont;
    integer t;
    begin
      for (t = 2; t < 4; t = t + 1) begin
        setup(16'h1000, 16'h2000, 16'h0002);
        go({8'h01, 4'h5, t[1:0], 2'h1}, t - 1);
        rd_chk(`OFS_CONTROL, {8'h01, 4'h5, t[1:0], 2'h1}, `RESP_OKAY);
        axi_wr(`OFS_CONTROL, 16'h0000, `RESP_OKAY);
        repeat (8) @(posedge aclk);
        go(16'h0000, 0);
        repeat (20) @(posedge aclk);
        check(16'(rd_q.size()), 16'h0000);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_modes;
    t_reload;
    t_off;
    t_cont;
    end_of_test;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
endmodule
